/* logic/addr_mode_pkg.sv */
/*
  Constants, register map and state codes of the operand addressing block.
  Assumes a 32-bit classic Wishbone register bus and a byte-wide memory port.
*/
package addr_mode_pkg;
  // ==========================================================================
  // Widths
  localparam int unsigned WB_AW = 6;
  localparam int unsigned ADDR_W = 15;
  localparam int unsigned PAGE_OFS_W = 13;
  localparam int unsigned DISP_W = 7;
  localparam int unsigned NUM_REGS = 7;
  localparam int unsigned PSW_W = 4;
  // ==========================================================================
  // Register offsets (byte addresses)
  localparam logic [WB_AW-1:0] OFS_CTRL = 6'h00;
  localparam logic [WB_AW-1:0] OFS_INSTR = 6'h04;
  localparam logic [WB_AW-1:0] OFS_IAR = 6'h08;
  localparam logic [WB_AW-1:0] OFS_PSW = 6'h0C;
  localparam logic [WB_AW-1:0] OFS_EA = 6'h10;
  localparam logic [WB_AW-1:0] OFS_OPND = 6'h14;
  localparam logic [WB_AW-1:0] OFS_STAT = 6'h18;
  localparam int unsigned REG_AREA_BIT = 5;
  localparam logic [2:0] REG_HOLE = 3'h7;
  // ==========================================================================
  // Field positions
  localparam int unsigned CTRL_START_BIT = 0;
  localparam int unsigned CTRL_FMT_LSB = 1;
  localparam int unsigned CTRL_OP_LSB = 4;
  localparam int unsigned PSW_CC_LSB = 0;
  localparam int unsigned PSW_BANK_BIT = 2;
  localparam int unsigned PSW_INH_BIT = 3;
  localparam int unsigned STAT_BUSY_BIT = 0;
  localparam int unsigned STAT_IND_BIT = 1;
  localparam int unsigned B1_LSB = 8;
  localparam int unsigned B2_LSB = 16;
  localparam int unsigned IND_BIT = 7;
  localparam int unsigned IDX_HI_BIT = 6;
  localparam int unsigned IDX_LO_BIT = 5;
  localparam int unsigned ABS_HI_MSB = 4;
  // ==========================================================================
  // Reset values and steps
  localparam logic [ADDR_W-1:0] IAR_RESET = 15'h0000;
  localparam logic [PSW_W-1:0] PSW_RESET = 4'h0;
  localparam logic [ADDR_W-1:0] LEN_1 = 15'h0001;
  localparam logic [ADDR_W-1:0] LEN_2 = 15'h0002;
  localparam logic [ADDR_W-1:0] LEN_3 = 15'h0003;
  localparam logic [7:0] IDX_STEP = 8'h01;
  // ==========================================================================
  // Codes
  typedef enum logic [2:0] {
    FMT_REG = 3'h0, FMT_IMM = 3'h1, FMT_REL = 3'h2, FMT_ABS = 3'h3, FMT_ZREL = 3'h4
  } fmt_e;
  typedef enum logic [1:0] {OP_LOAD = 2'h0, OP_STORE = 2'h1, OP_CMP = 2'h2, OP_NONE = 2'h3} op_e;
  localparam logic [1:0] IDX_NONE = 2'h0;
  localparam logic [1:0] IDX_INC = 2'h1;
  localparam logic [1:0] IDX_DEC = 2'h2;
  localparam logic [1:0] CC_ZERO = 2'h0;
  localparam logic [1:0] CC_POS = 2'h1;
  localparam logic [1:0] CC_NEG = 2'h2;
  typedef enum logic [5:0] {
    S_IDLE = 6'h01, S_EXEC = 6'h02, S_VEC = 6'h04, S_IND_HI = 6'h08, S_IND_LO = 6'h10, S_OPRD = 6'h20
  } state_e;
endpackage : addr_mode_pkg

/* logic/addressing_mode_decoder.sv */
/*
  Operand addressing unit of an 8-bit core: decodes formats, forms effective
  addresses, fetches indirect pointers and operands, keeps the result flags.
  Assumes classic Wishbone slave access and a byte memory port with ack.
*/
// Our own choices: the Wishbone register port and the address map.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Result flags update after every move into a register and every compare.
// - Flags say positive, zero or negative; negative when bit 7 is one.
// - Reset held three clocks; afterwards the first fetch address is zero.
// - Interrupt present at reset release runs the normal acknowledge and vector.
// - Reset clears the interrupt inhibit bit.
// - Register format: one byte, two-bit field, register zero is other operand.
// - Single-operand register format may name register zero or bank registers.
// - Immediate format: two bytes, second byte is the operand itself.
// - Relative displacement is the low seven bits, signed, -64 to +63.
// - Relative address is next instruction address plus displacement.
// - Top bit of relative second byte requests an indirect cycle.
// - Zero-page relative jump and call are relative to address zero.
// - Indirect pointer is two bytes, 15 bits right justified, top ignored.
// - Absolute format: three bytes, 13-bit address within current page.
// - Bits 6 and 5 of second byte select the index control.
// - No indexing: field names argument, address field is effective address.
// - Indexed only: field names index, register zero is argument, unsigned add.
// - Indexing with indirection adds index to fetched pointer.
// - Increment or decrement index by one before forming the address.
module addressing_mode_decoder (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [addr_mode_pkg::WB_AW-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  output logic [addr_mode_pkg::ADDR_W-1:0] mem_adr_o,
  output logic mem_req_o,
  input wire logic [7:0] mem_dat_i,
  input wire logic mem_ack_i,
  input wire logic irq_line_i,
  output logic intack_o
);
  import addr_mode_pkg::*;

  // ==========================================================================
  // State
  state_e state_q, state_d;
  fmt_e fmt_q, fmt_d;
  op_e op_q, op_d;
  logic [23:0] instr_q, instr_d;
  logic [ADDR_W-1:0] iar_q, iar_d, ea_q, ea_d, addr_q, addr_d;
  logic [PSW_W-1:0] processor_state_word_q, processor_state_word_d;
  logic [7:0] opnd_q, opnd_d, idx_q, idx_d;
  logic [6:0] ptr_hi_q, ptr_hi_d;
  logic ind_q, ind_d;
  logic [7:0] regs_q [NUM_REGS];
  logic [7:0] regs_d [NUM_REGS];
  logic ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;

  // ==========================================================================
  // Instruction field decode
  logic [7:0] b0, b1, b2;
  logic [1:0] rsel, idx_ctl;
  logic [2:0] ri, arg_ri, dst_ri;
  logic indexed, indir, needs_rd;
  logic [7:0] idx_new;
  logic [PAGE_OFS_W-1:0] field;
  logic [ADDR_W-1:0] ptr;
  logic [31:0] wmask;
  logic bus_req, wr_go;

  // Byte split and register selection within the active bank
  assign b0 = instr_q[7:0];
  assign b1 = instr_q[B1_LSB +: 8];
  assign b2 = instr_q[B2_LSB +: 8];
  assign rsel = b0[1:0];
  assign ri = (rsel == 2'h0) ? 3'h0 :
    (processor_state_word_q[PSW_BANK_BIT] ? 3'({1'b0, rsel}) + 3'h3 : 3'({1'b0, rsel}));
  assign idx_ctl = b1[IDX_HI_BIT:IDX_LO_BIT];
  assign indexed = (fmt_q == FMT_ABS) && (idx_ctl != IDX_NONE);
  assign indir = b1[IND_BIT];
  assign arg_ri = indexed ? 3'h0 : ri;
  assign dst_ri = (fmt_q == FMT_REG || indexed) ? 3'h0 : ri;
  assign field = {b1[ABS_HI_MSB:0], b2};
  assign needs_rd = (op_q == OP_LOAD) || (op_q == OP_CMP);
  assign ptr = {ptr_hi_q, mem_dat_i};

  // Pre-increment or pre-decrement of the index, wrapping at a byte
  always_comb begin
    idx_new = regs_q[ri];
    if (idx_ctl == IDX_INC) idx_new = regs_q[ri] + IDX_STEP;
    if (idx_ctl == IDX_DEC) idx_new = regs_q[ri] - IDX_STEP;
  end

  // ==========================================================================
  // Relative address unit
  ea_calc_if rel_bus ();
  assign rel_bus.base = iar_q + LEN_2;
  assign rel_bus.disp = b1;
  assign rel_bus.zp = (fmt_q == FMT_ZREL);
  rel_addr_unit u_rel (
    .rel(rel_bus)
  );

  // ==========================================================================
  // Completion: operand selection and flag classification
  logic fin, cmp_en;
  logic [7:0] fin_opnd, cmp_a;
  logic [1:0] result_sign_flags;

  always_comb begin
    fin = 1'b0;
    fin_opnd = opnd_q;
    unique case (state_q)
      S_EXEC: begin
        if (fmt_q == FMT_REG) begin
          fin = 1'b1;
          fin_opnd = regs_q[ri];
        end else if (fmt_q == FMT_IMM) begin
          fin = 1'b1;
          fin_opnd = b1;
        end
      end
      S_OPRD: begin
        fin = mem_ack_i;
        fin_opnd = mem_dat_i;
      end
      default: ;
    endcase
    cmp_en = (op_q == OP_CMP);
    if (cmp_en) cmp_a = (fmt_q == FMT_REG) ? regs_q[0] : regs_q[arg_ri];
    else if (op_q == OP_STORE) cmp_a = regs_q[0];
    else cmp_a = fin_opnd;
  end

  sign_flags_unit u_flags (
    .a_i(cmp_a),
    .b_i(fin_opnd),
    .cmp_i(cmp_en),
    .flags_o(result_sign_flags)
  );

  // ==========================================================================
  // Register bus: one wait cycle, write at the acknowledging edge
  assign bus_req = wb_cyc_i & wb_stb_i;
  assign wr_go = bus_req & wb_we_i & ack_q;
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // Read data capture and acknowledge
  always_comb begin
    ack_d = bus_req & ~ack_q;
    rdat_d = rdat_q;
    if (bus_req & ~ack_q) begin
      rdat_d = 32'h0000_0000;
      if (wb_adr_i[REG_AREA_BIT]) begin
        if (wb_adr_i[4:2] != REG_HOLE) rdat_d[7:0] = regs_q[wb_adr_i[4:2]];
      end else begin
        unique case (wb_adr_i)
          OFS_CTRL: begin
            rdat_d[CTRL_FMT_LSB +: 3] = fmt_q;
            rdat_d[CTRL_OP_LSB +: 2] = op_q;
          end
          OFS_INSTR: rdat_d[23:0] = instr_q;
          OFS_IAR: rdat_d[ADDR_W-1:0] = iar_q;
          OFS_PSW: rdat_d[PSW_W-1:0] = processor_state_word_q;
          OFS_EA: rdat_d[ADDR_W-1:0] = ea_q;
          OFS_OPND: rdat_d[7:0] = opnd_q;
          OFS_STAT: begin
            rdat_d[STAT_BUSY_BIT] = (state_q != S_IDLE);
            rdat_d[STAT_IND_BIT] = ind_q;
          end
          default: ;
        endcase
      end
    end
  end

  // Bus registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // ==========================================================================
  // Sequencer and datapath next values
  always_comb begin
    state_d = state_q;
    fmt_d = fmt_q;
    op_d = op_q;
    instr_d = instr_q;
    iar_d = iar_q;
    ea_d = ea_q;
    addr_d = addr_q;
    processor_state_word_d = processor_state_word_q;
    opnd_d = opnd_q;
    idx_d = idx_q;
    ptr_hi_d = ptr_hi_q;
    ind_d = ind_q;
    regs_d = regs_q;
    // Software writes
    if (wr_go) begin
      if (wb_adr_i[REG_AREA_BIT]) begin
        if (wb_sel_i[0] && wb_adr_i[4:2] != REG_HOLE) regs_d[wb_adr_i[4:2]] = wb_dat_i[7:0];
      end else begin
        unique case (wb_adr_i)
          OFS_CTRL: begin
            if (state_q == S_IDLE && wb_sel_i[0] && wb_dat_i[CTRL_START_BIT]) begin
              fmt_d = fmt_e'(wb_dat_i[CTRL_FMT_LSB +: 3]);
              op_d = op_e'(wb_dat_i[CTRL_OP_LSB +: 2]);
              state_d = S_EXEC;
            end
          end
          OFS_INSTR: instr_d = (instr_q & ~wmask[23:0]) | (wb_dat_i[23:0] & wmask[23:0]);
          OFS_IAR: iar_d = (iar_q & ~wmask[ADDR_W-1:0]) | (wb_dat_i[ADDR_W-1:0] & wmask[ADDR_W-1:0]);
          OFS_PSW: if (wb_sel_i[0]) processor_state_word_d = wb_dat_i[PSW_W-1:0];
          default: ;
        endcase
      end
    end
    // Address formation
    unique case (state_q)
      S_IDLE: begin
        if (irq_line_i && !processor_state_word_q[PSW_INH_BIT]) begin
          processor_state_word_d[PSW_INH_BIT] = 1'b1;
          state_d = S_VEC;
        end
      end
      S_VEC: begin
        if (mem_ack_i) begin
          instr_d[B1_LSB +: 8] = mem_dat_i;
          fmt_d = FMT_ZREL;
          op_d = OP_NONE;
          state_d = S_EXEC;
        end
      end
      S_EXEC: begin
        state_d = S_IDLE;
        unique case (fmt_q)
          FMT_REG: iar_d = iar_q + LEN_1;
          FMT_IMM: iar_d = iar_q + LEN_2;
          FMT_REL, FMT_ZREL: begin
            ea_d = rel_bus.ea;
            ind_d = indir;
            if (fmt_q == FMT_REL) iar_d = iar_q + LEN_2;
            if (indir) begin
              addr_d = rel_bus.ea;
              state_d = S_IND_HI;
            end else if (fmt_q == FMT_ZREL) begin
              iar_d = rel_bus.ea;
            end else if (needs_rd) begin
              addr_d = rel_bus.ea;
              state_d = S_OPRD;
            end
          end
          FMT_ABS: begin
            iar_d = iar_q + LEN_3;
            ind_d = indir;
            idx_d = idx_new;
            if (indexed) regs_d[ri] = idx_new;
            if (indir) begin
              addr_d = {iar_q[ADDR_W-1:PAGE_OFS_W], field};
              ea_d = addr_d;
              state_d = S_IND_HI;
            end else begin
              ea_d = {iar_q[ADDR_W-1:PAGE_OFS_W], indexed ? field + {5'h00, idx_new} : field};
              if (needs_rd) begin
                addr_d = ea_d;
                state_d = S_OPRD;
              end
            end
          end
          default: ;
        endcase
      end
      S_IND_HI: begin
        if (mem_ack_i) begin
          ptr_hi_d = mem_dat_i[6:0];
          addr_d = addr_q + LEN_1;
          state_d = S_IND_LO;
        end
      end
      S_IND_LO: begin
        if (mem_ack_i) begin
          ea_d = indexed ? ptr + {7'h00, idx_q} : ptr;
          state_d = S_IDLE;
          if (fmt_q == FMT_ZREL) begin
            iar_d = ptr;
          end else if (needs_rd) begin
            addr_d = ea_d;
            state_d = S_OPRD;
          end
        end
      end
      S_OPRD: if (mem_ack_i) state_d = S_IDLE;
      default: state_d = S_IDLE;
    endcase
    // Result write and flag update
    if (fin) begin
      state_d = S_IDLE;
      opnd_d = fin_opnd;
      unique case (op_q)
        OP_LOAD: begin
          regs_d[dst_ri] = fin_opnd;
          processor_state_word_d[PSW_CC_LSB +: 2] = result_sign_flags;
        end
        OP_CMP: processor_state_word_d[PSW_CC_LSB +: 2] = result_sign_flags;
        OP_STORE: begin
          if (fmt_q == FMT_REG) begin
            regs_d[ri] = regs_q[0];
            processor_state_word_d[PSW_CC_LSB +: 2] = result_sign_flags;
          end
        end
        default: ;
      endcase
    end
  end

  // Sequencer registers; reset starts at address zero with interrupts allowed
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= S_IDLE;
      fmt_q <= FMT_REG;
      op_q <= OP_NONE;
      instr_q <= 24'h000000;
      iar_q <= IAR_RESET;
      ea_q <= IAR_RESET;
      addr_q <= IAR_RESET;
      processor_state_word_q <= PSW_RESET;
      opnd_q <= 8'h00;
      idx_q <= 8'h00;
      ptr_hi_q <= 7'h00;
      ind_q <= 1'b0;
      for (int i = 0; i < NUM_REGS; i++) regs_q[i] <= 8'h00;
    end else begin
      state_q <= state_d;
      fmt_q <= fmt_d;
      op_q <= op_d;
      instr_q <= instr_d;
      iar_q <= iar_d;
      ea_q <= ea_d;
      addr_q <= addr_d;
      processor_state_word_q <= processor_state_word_d;
      opnd_q <= opnd_d;
      idx_q <= idx_d;
      ptr_hi_q <= ptr_hi_d;
      ind_q <= ind_d;
      regs_q <= regs_d;
    end
  end

  // ==========================================================================
  // Memory port
  assign mem_req_o = (state_q == S_VEC) || (state_q == S_IND_HI) || (state_q == S_IND_LO) || (state_q == S_OPRD);
  assign intack_o = (state_q == S_VEC);
  assign mem_adr_o = addr_q;
endmodule : addressing_mode_decoder
`default_nettype wire

/* logic/ea_calc_if.sv */
/*
  Carries the relative displacement request and its effective address.
  Assumes one user and one address unit on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface ea_calc_if;
  logic [14:0] base;
  logic [7:0] disp;
  logic zp;
  logic [14:0] ea;
  modport unit (input base, input disp, input zp, output ea);
  modport user (output base, output disp, output zp, input ea);
endinterface : ea_calc_if
`default_nettype wire

/* logic/rel_addr_unit.sv */
/*
  Relative effective address: base plus 7-bit signed displacement, in page; with zp, the displacement alone, in page zero.
  Assumes base already points past the two-byte instruction.
*/
`timescale 1ns/1ps
`default_nettype none
module rel_addr_unit (
  ea_calc_if.unit rel
);
  import addr_mode_pkg::*;
  logic [PAGE_OFS_W-1:0] disp_ext;
  // ==========================================================================
  // Sign extension and page-bound addition
  always_comb begin
    disp_ext = {{(PAGE_OFS_W-DISP_W){rel.disp[DISP_W-1]}}, rel.disp[DISP_W-1:0]};
    if (rel.zp) begin
      rel.ea = {2'h0, disp_ext};
    end else begin
      rel.ea = {rel.base[ADDR_W-1:PAGE_OFS_W], rel.base[PAGE_OFS_W-1:0] + disp_ext};
    end
  end
endmodule : rel_addr_unit
`default_nettype wire

/* logic/sign_flags_unit.sv */
/*
  Two-bit result class of a byte, or of a signed compare of two bytes.
  Assumes purely combinational use.
*/
`timescale 1ns/1ps
`default_nettype none
module sign_flags_unit (
  input wire logic [7:0] a_i,
  input wire logic [7:0] b_i,
  input wire logic cmp_i,
  output logic [1:0] flags_o
);
  import addr_mode_pkg::*;
  // ==========================================================================
  // Classification
  always_comb begin
    if (cmp_i) begin
      if (a_i == b_i) flags_o = CC_ZERO;
      else if ($signed(a_i) > $signed(b_i)) flags_o = CC_POS;
      else flags_o = CC_NEG;
    end else if (a_i[7]) begin
      flags_o = CC_NEG;
    end else if (a_i == 8'h00) begin
      flags_o = CC_ZERO;
    end else begin
      flags_o = CC_POS;
    end
  end
endmodule : sign_flags_unit
`default_nettype wire

/* verification/addressing_mode_decoder_checker.sv */
/*
  Concurrent checks on the decoder's bus, memory and interrupt handshakes.
  Assumes a bind to addressing_mode_decoder: one clock, synchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
module addressing_mode_decoder_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [addr_mode_pkg::ADDR_W-1:0] mem_adr_o,
  input wire logic mem_req_o,
  input wire logic mem_ack_i,
  input wire logic irq_line_i,
  input wire logic intack_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ==========================================================================
  // Register bus
  AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered next cycle");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_ACK_CAUSE: assert property (wb_ack_o |-> wb_cyc_i && wb_stb_i)
    else $error("ack without request");
  // ==========================================================================
  // Start-up and interrupt
  AST_RST_QUIET: assert property ($fell(rst_i) |-> !wb_ack_o && !mem_req_o && !intack_o)
    else $error("outputs active at reset release");
  AST_IRQ_START: assert property ($fell(rst_i) && irq_line_i |=> intack_o && mem_req_o)
    else $error("interrupt at reset release not acknowledged");
  AST_INTACK_REQ: assert property (intack_o |-> mem_req_o)
    else $error("intack without memory request");
  AST_INTACK_CAUSE: assert property ($rose(intack_o) |-> $past(irq_line_i))
    else $error("intack without interrupt request");
  AST_VEC_ONE: assert property (intack_o && mem_ack_i |=> !intack_o)
    else $error("vector fetch longer than one byte");
  // ==========================================================================
  // Memory port
  AST_REQ_HOLD: assert property (mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_adr_o))
    else $error("memory request dropped or moved before ack");
endmodule : addressing_mode_decoder_checker
`default_nettype wire

/* verification/mem_model.sv */
/*
  Byte memory and interrupting device on the decoder's memory port.
  Assumes one request at a time, answered once by a one-cycle ack.
*/
`timescale 1ns/1ps
`default_nettype none
module mem_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [addr_mode_pkg::ADDR_W-1:0] adr_i,
  input wire logic req_i,
  input wire logic intack_i,
  input wire logic slow_i,
  input wire logic [7:0] vec_i,
  output logic [7:0] dat_o,
  output logic ack_o
);
  import addr_mode_pkg::*;
  logic [7:0] mem [0:32767];
  logic [1:0] wait_q;
  // Each byte holds the low byte of its own address
  initial begin
    for (int a = 0; a < 32768; a++) begin
      mem[a] = a[7:0];
    end
    dat_o = 8'h00;
    ack_o = 1'b0;
    wait_q = 2'h0;
  end
  // Answer after 0 or 3 waits; data lines toggle outside an answer
  always @(posedge clk_i) begin
    if (rst_i || ack_o || !req_i) begin
      ack_o <= 1'b0;
      wait_q <= 2'h0;
      dat_o <= ~dat_o;
    end else if (slow_i && wait_q != 2'h3) begin
      wait_q <= wait_q + 2'h1;
      dat_o <= ~dat_o;
    end else begin
      ack_o <= 1'b1;
      dat_o <= intack_i ? vec_i : mem[adr_i];
    end
  end
endmodule : mem_model
`default_nettype wire

/* verification/tb_addressing_mode_decoder.sv */
/*
  Self-checking bench: a table of formats, then bus refusals and start-up.
  Assumes mem_model on the memory port and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_addressing_mode_decoder;
  import addr_mode_pkg::*;
  typedef struct packed {
    logic [23:0] ins;
    logic [5:0] ctl;
    logic [7:0] ix;
    logic [1:0] fl;
    logic [14:0] ea;
    logic [7:0] ix_end;
  } row_s;
  logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic irq = 1'b0, slow = 1'b0, ack, mreq, mack, intack;
  logic [5:0] adr = 6'h00;
  logic [31:0] wdat = 32'h0, rd, rdat;
  logic [7:0] vec = 8'h00, mdat;
  logic [14:0] madr;
  int n_errors = 0, comparisons = 0, cycles = 0;
  row_s rows [19];
  // ==========================================================================
  // Clock, design and partner
  always #5 clk = ~clk;
  addressing_mode_decoder DUT (.clk_i(clk), .rst_i(rst), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_sel_i(4'hF), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack),
    .wb_dat_o(rdat), .mem_adr_o(madr), .mem_req_o(mreq), .mem_dat_i(mdat),
    .mem_ack_i(mack), .irq_line_i(irq), .intack_o(intack));
  mem_model u_mem (.clk_i(clk), .rst_i(rst), .adr_i(madr), .req_i(mreq), .intack_i(intack),
    .slow_i(slow), .vec_i(vec), .dat_o(mdat), .ack_o(mack));
  // ==========================================================================
  // Tasks
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : conclude
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // One classic cycle, held until ack is sampled
  task automatic wb(input logic [5:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb
  task automatic idle;
    do wb(OFS_STAT, 1'b0, 32'h0); while (rd[STAT_BUSY_BIT] !== 1'b0);
  endtask : idle
  // Cuts a hang short
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      conclude();
    end
  end
  // ==========================================================================
  // Main sequence
  initial begin
    row_s r;
    rows = '{
      '{24'h000001, 6'h01, 8'h80, 2'h2, 15'h0000, 8'h80},
      '{24'h000002, 6'h03, 8'h80, 2'h0, 15'h0000, 8'h80},
      '{24'h007F02, 6'h03, 8'h80, 2'h1, 15'h0000, 8'h80},
      '{24'h000001, 6'h23, 8'h80, 2'h2, 15'h0000, 8'h80},
      '{24'h008001, 6'h23, 8'h80, 2'h0, 15'h0000, 8'h80},
      '{24'h008001, 6'h23, 8'h05, 2'h1, 15'h0000, 8'h05},
      '{24'h003F02, 6'h05, 8'h80, 2'h1, 15'h2141, 8'h80},
      '{24'h004002, 6'h05, 8'h80, 2'h2, 15'h20C2, 8'h80},
      '{24'h008202, 6'h05, 8'h80, 2'h1, 15'h0405, 8'h80},
      '{24'h007F00, 6'h39, 8'h80, 2'h1, 15'h1FFF, 8'h80},
      '{24'h801F02, 6'h07, 8'h80, 2'h2, 15'h3F80, 8'h80},
      '{24'h106001, 6'h07, 8'h80, 2'h2, 15'h2090, 8'h80},
      '{24'hFF2001, 6'h07, 8'hFF, 2'h2, 15'h20FF, 8'h00},
      '{24'h004001, 6'h07, 8'h00, 2'h2, 15'h20FF, 8'hFF},
      '{24'h30E001, 6'h07, 8'h10, 2'h1, 15'h3041, 8'h10},
      '{24'hFF7F01, 6'h07, 8'h02, 2'h1, 15'h2001, 8'h02},
      '{24'h000001, 6'h23, 8'h80, 2'h2, 15'h0000, 8'h80},
      '{24'h801F02, 6'h17, 8'h80, 2'h2, 15'h3F80, 8'h80},
      '{24'h000001, 6'h11, 8'h80, 2'h1, 15'h0000, 8'h01}};
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    // Table: preset index, place, instruction, start, then read back
    foreach (rows[i]) begin
      r = rows[i];
      slow <= i[0];
      wb(6'h24, 1'b1, {24'h0, r.ix});
      wb(OFS_IAR, 1'b1, 32'h2100);
      wb(OFS_INSTR, 1'b1, {8'h0, r.ins});
      wb(OFS_CTRL, 1'b1, {26'h0, r.ctl});
      idle();
      wb(OFS_PSW, 1'b0, 32'h0);
      check(rd[1:0], r.fl);
      if (r.ctl[3:1] >= 3'h2) begin
        wb(OFS_EA, 1'b0, 32'h0);
        check(rd[14:0], r.ea);
      end
      wb(6'h24, 1'b0, 32'h0);
      check(rd[7:0], r.ix_end);
    end
    $display("format table done");
    // Second bank: field 1 now names register four
    wb(OFS_PSW, 1'b1, 32'h04);
    wb(6'h30, 1'b1, 32'h9C);
    wb(OFS_INSTR, 1'b1, 32'h01);
    wb(OFS_CTRL, 1'b1, 32'h01);
    idle();
    wb(6'h20, 1'b0, 32'h0);
    check(rd[7:0], 8'h9C);
    wb(OFS_PSW, 1'b0, 32'h0);
    check(rd[3:0], 4'h6);
    $display("bank select done");
    // Read-only and unmapped places
    wb(OFS_EA, 1'b1, 32'h7FFF);
    wb(6'h3C, 1'b1, 32'hFF);
    wb(OFS_EA, 1'b0, 32'h0);
    check(rd[14:0], 15'h3F80);
    wb(6'h3C, 1'b0, 32'h0);
    check(rd, 32'h0);
    $display("bus refusals done");
    // Inhibit set by software, then a short reset with an interrupt pending
    wb(OFS_PSW, 1'b1, 32'h08);
    irq <= 1'b1;
    vec <= 8'hFF;
    slow <= 1'b1;
    repeat (3) @(posedge clk);
    check(intack, 1'b0);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (3) begin
      do @(posedge clk); while (mack !== 1'b1);
    end
    repeat (2) @(posedge clk);
    wb(OFS_IAR, 1'b0, 32'h0);
    check(rd[14:0], 15'h7F00);
    wb(OFS_PSW, 1'b0, 32'h0);
    check(rd[3:0], 4'h8);
    irq <= 1'b0;
    $display("start-up with interrupt done");
    // Plain reset: start address and state word cleared
    rst <= 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    wb(OFS_IAR, 1'b0, 32'h0);
    check(rd, 32'h0);
    wb(OFS_PSW, 1'b0, 32'h0);
    check(rd, 32'h0);
    $display("plain reset done");
    conclude();
  end
endmodule : tb_addressing_mode_decoder
bind addressing_mode_decoder addressing_mode_decoder_checker u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .mem_adr_o(mem_adr_o),
  .mem_req_o(mem_req_o), .mem_ack_i(mem_ack_i), .irq_line_i(irq_line_i), .intack_o(intack_o));
`default_nettype wire
